// ==== shared/fault_bank_map.vh ====
// Command codes, supported-bit masks and field positions of the fault and status bank.
// Assumes inclusion by the bank module only; definitions only.
`ifndef FAULT_BANK_MAP_VH
`define FAULT_BANK_MAP_VH

// ----------------------------------------------------------------
// Command codes (register addresses)
// ----------------------------------------------------------------
`define CMD_CLEAR_FAULTS          8'h03
`define CMD_STATUS_WORD           8'h79
`define CMD_OUTPUT_CURRENT_STATUS 8'h7b
`define CMD_INPUT_SUPPLY_STATUS   8'h7c
`define CMD_EXTERNAL_HEAT_STATUS  8'h7d
`define CMD_COMM_MEMORY_STATUS    8'h7e
`define CMD_DEVICE_SPECIFIC       8'h80
`define CMD_MEMORY_CORRECTION     8'hb6
`define CMD_PIN_STATE_REPORT      8'he5
`define CMD_COMMON_DEVICE_FLAGS   8'hef

// ----------------------------------------------------------------
// Supported-bit masks and write-one-to-clear masks
// ----------------------------------------------------------------
`define MASK_OUTPUT_CURRENT       8'ha8
`define MASK_INPUT_SUPPLY         8'ha8
`define W1C_INPUT_SUPPLY          8'h80
`define MASK_EXTERNAL_HEAT        8'hc0
`define MASK_COMM_MEMORY          8'hfb
`define MASK_DEVICE_SPECIFIC      8'hfb
`define MASK_COMMON_FLAGS         8'hfa
`define MASK_PIN_STATE            16'hcfff

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define BIT_DEVICE_SUMMARY        12
`define BIT_ECC_CLEAN             5
`define BIT_COMMON_NOT_ALERTING   7
`define RESET_STATUS              8'h00

`endif

// ==== verilog/pmbus_fault_status_bank.v ====
// Fault and status register bank of a dual-channel power controller.
// Assumes a command decoder on CLK presents one-cycle write, read and clear strobes,
// and that fault sources are synchronous levels; pin levels are synchronised here.
//
// Operation
// - Output-current byte: overcurrent fault bit 7, warning bit 5, power-stage fault bit 3.
// - Unsupported status bits always read back zero.
// - Writing 1 clears supported bits of current, heat, comm and device bytes.
// - Any supported bit set in those bytes may raise ALERT.
// - Input byte: overvoltage fault bit 7, undervoltage warning bit 5, off-for-low-input bit 3.
// - In the input byte only bit 7 raises ALERT and is write-one-clearable.
// - External heat byte: fault bit 7, warning bit 6, lower bits zero.
// - Comm byte: bad command bit 7, bad data bit 6, packet check failure bit 5.
// - Comm byte: memory 4, processor 3, other comm 1, other logic 0; bit 2 zero.
// - Device byte: heat fault, heat warning, CRC, PLL, log, short, fault pin flags.
// - Any device-specific bit sets status word summary bit and may raise ALERT.
// - Pin word: stages ready 15/14, temperature invalid 11, sync off 10, power-good 9/8.
// - Pin word bits 7:0: run pin forcing and levels, fault pin forcing and levels.
// - Common byte: not alerting, not busy, no calc, steady, memory ready, timeout.
// - Info word bit 5 is zero when memory corrections were made; rest reserved.
// - Clear-faults clears every fault bit at once and releases ALERT when no fault is still present.
// - Clear-faults never restarts a latched-off channel.
// - Latched channel restarts only after off-then-on command or power cycle.
// - A fault still present at clear-faults is set again at once.
// - Current, input and comm status move as single data bytes.
// - Device summary flag is bit 12 of the status word.
`timescale 1ns/100ps
`include "fault_bank_map.vh"

module pmbus_fault_status_bank (
  // Clock and reset
  input  wire        CLK,
  input  wire        RESETN,
  // Register access from the command decoder
  input  wire [7:0]  CMD_CODE,
  input  wire        WRITE_STROBE,
  input  wire        CLEAR_STROBE,
  input  wire        READ_STROBE,
  input  wire [7:0]  WRITE_DATA,
  output reg  [15:0] READ_DATA,
  output reg         READ_VALID,
  output reg         READ_UNKNOWN,
  // Fault sources, one-cycle or level events from internal logic
  input  wire [7:0]  CURRENT_EVENTS,
  input  wire [7:0]  INPUT_EVENTS,
  input  wire [7:0]  HEAT_EVENTS,
  input  wire [7:0]  COMM_EVENTS,
  input  wire [7:0]  DEVICE_EVENTS,
  // Internal live state
  input  wire [1:0]  STAGES_READY,
  input  wire        TEMP_MAYBE_INVALID,
  input  wire [1:0]  POWER_GOOD,
  input  wire [1:0]  FORCING_ENABLE_LOW,
  input  wire [1:0]  FORCING_FAULT_LOW,
  input  wire        NOT_BUSY,
  input  wire        NO_CALC_PENDING,
  input  wire        OUTPUT_STEADY,
  input  wire        MEMORY_INITIALIZED,
  input  wire        ECC_CORRECTED,
  // Pins, asynchronous to CLK
  input  wire        SYNC_DISABLED_PIN,
  input  wire        CHANNEL_ZERO_ENABLE_PIN,
  input  wire        CHANNEL_ONE_ENABLE_PIN,
  input  wire        CHANNEL_ZERO_FAULT_LINE,
  input  wire        CHANNEL_ONE_FAULT_LINE,
  input  wire        SHARED_TIMEBASE_TIMEOUT,
  // Alert and summary
  input  wire [7:0]  ALERT_MASK,
  output reg         ALERT_N_OE,
  output reg         DEVICE_SUMMARY_FLAG
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg  [5:0] pin_meta;
  reg  [5:0] pin_sync;
  wire [5:0] pin_raw;
  assign pin_raw = {SHARED_TIMEBASE_TIMEOUT, SYNC_DISABLED_PIN, CHANNEL_ONE_ENABLE_PIN,
                    CHANNEL_ZERO_ENABLE_PIN, CHANNEL_ONE_FAULT_LINE, CHANNEL_ZERO_FAULT_LINE};

  always @(posedge CLK) begin
    if (!RESETN) begin
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------------------------------
  // Sticky status update
  // ----------------------------------------------------------------
  // Set wins over any clear, so a fault still present at a clear stays set.
  function [7:0] sticky;
    input [7:0] cur;
    input [7:0] ev;
    input [7:0] mask;
    input [7:0] w1c_mask;
    input       wr;
    input [7:0] wdata;
    input       clr_all;
    reg   [7:0] kept;
    begin
      kept = cur;
      if (clr_all)
        kept = 8'h00;
      else if (wr)
        kept = cur & ~(wdata & w1c_mask);
      sticky = (kept | ev) & mask;
    end
  endfunction

  reg [7:0] current_status;
  reg [7:0] input_status;
  reg [7:0] heat_status;
  reg [7:0] comm_status;
  reg [7:0] device_status;

  wire wr_current = WRITE_STROBE && (CMD_CODE == `CMD_OUTPUT_CURRENT_STATUS);
  wire wr_input   = WRITE_STROBE && (CMD_CODE == `CMD_INPUT_SUPPLY_STATUS);
  wire wr_heat    = WRITE_STROBE && (CMD_CODE == `CMD_EXTERNAL_HEAT_STATUS);
  wire wr_comm    = WRITE_STROBE && (CMD_CODE == `CMD_COMM_MEMORY_STATUS);
  wire wr_device  = WRITE_STROBE && (CMD_CODE == `CMD_DEVICE_SPECIFIC);
  // Clear-faults touches status bits only; channel latch-off lives elsewhere and is untouched.
  wire clr_all    = CLEAR_STROBE;

  always @(posedge CLK) begin
    if (!RESETN) begin
      current_status <= `RESET_STATUS;
      input_status   <= `RESET_STATUS;
      heat_status    <= `RESET_STATUS;
      comm_status    <= `RESET_STATUS;
      device_status  <= `RESET_STATUS;
    end else begin
      current_status <= sticky(current_status, CURRENT_EVENTS, `MASK_OUTPUT_CURRENT,
                               `MASK_OUTPUT_CURRENT, wr_current, WRITE_DATA, clr_all);
      input_status   <= sticky(input_status, INPUT_EVENTS, `MASK_INPUT_SUPPLY,
                               `W1C_INPUT_SUPPLY, wr_input, WRITE_DATA, clr_all);
      heat_status    <= sticky(heat_status, HEAT_EVENTS, `MASK_EXTERNAL_HEAT,
                               `MASK_EXTERNAL_HEAT, wr_heat, WRITE_DATA, clr_all);
      comm_status    <= sticky(comm_status, COMM_EVENTS, `MASK_COMM_MEMORY,
                               `MASK_COMM_MEMORY, wr_comm, WRITE_DATA, clr_all);
      device_status  <= sticky(device_status, DEVICE_EVENTS, `MASK_DEVICE_SPECIFIC,
                               `MASK_DEVICE_SPECIFIC, wr_device, WRITE_DATA, clr_all);
    end
  end

  // ----------------------------------------------------------------
  // Alert and summary
  // ----------------------------------------------------------------
  // Mask bit order: current, input, heat, comm, device; a set mask bit blocks that byte.
  wire [4:0] byte_active;
  assign byte_active = {|device_status, |comm_status, |heat_status,
                        |(input_status & `W1C_INPUT_SUPPLY), |current_status};
  wire next_alert = |(byte_active & ~ALERT_MASK[4:0]);

  always @(posedge CLK) begin
    if (!RESETN) begin
      ALERT_N_OE          <= 1'b0;
      DEVICE_SUMMARY_FLAG <= 1'b0;
    end else begin
      ALERT_N_OE          <= next_alert;
      DEVICE_SUMMARY_FLAG <= |device_status;
    end
  end

  // ----------------------------------------------------------------
  // Read-only words
  // ----------------------------------------------------------------
  wire [15:0] pin_word;
  assign pin_word = {STAGES_READY[1], STAGES_READY[0], 2'b00, TEMP_MAYBE_INVALID, pin_sync[4],
                     POWER_GOOD[1], POWER_GOOD[0], FORCING_ENABLE_LOW[1], FORCING_ENABLE_LOW[0],
                     pin_sync[3], pin_sync[2], FORCING_FAULT_LOW[1], FORCING_FAULT_LOW[0],
                     pin_sync[1], pin_sync[0]} & `MASK_PIN_STATE;
  wire [7:0] common_byte;
  assign common_byte = {~ALERT_N_OE, NOT_BUSY, NO_CALC_PENDING, OUTPUT_STEADY,
                        MEMORY_INITIALIZED, 1'b0, pin_sync[5], 1'b0} & `MASK_COMMON_FLAGS;
  wire [15:0] info_word;
  assign info_word = {10'h000, ~ECC_CORRECTED, 5'h00};
  wire [15:0] status_word_high;
  assign status_word_high = {3'b000, |device_status, 12'h000};

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Byte registers return in the low byte with the high byte zero.
  reg [15:0] next_read;
  reg        next_unknown;
  always @* begin
    next_read    = 16'h0000;
    next_unknown = 1'b0;
    case (CMD_CODE)
      `CMD_OUTPUT_CURRENT_STATUS: next_read = {8'h00, current_status};
      `CMD_INPUT_SUPPLY_STATUS:   next_read = {8'h00, input_status};
      `CMD_EXTERNAL_HEAT_STATUS:  next_read = {8'h00, heat_status};
      `CMD_COMM_MEMORY_STATUS:    next_read = {8'h00, comm_status};
      `CMD_DEVICE_SPECIFIC:       next_read = {8'h00, device_status};
      `CMD_STATUS_WORD:           next_read = status_word_high;
      `CMD_PIN_STATE_REPORT:      next_read = pin_word;
      `CMD_COMMON_DEVICE_FLAGS:   next_read = {8'h00, common_byte};
      `CMD_MEMORY_CORRECTION:     next_read = info_word;
      default:                    next_unknown = 1'b1;
    endcase
  end

  always @(posedge CLK) begin
    if (!RESETN) begin
      READ_DATA    <= 16'h0000;
      READ_VALID   <= 1'b0;
      READ_UNKNOWN <= 1'b0;
    end else begin
      READ_VALID   <= READ_STROBE;
      READ_UNKNOWN <= READ_STROBE & next_unknown;
      if (READ_STROBE)
        READ_DATA <= next_read;
    end
  end

endmodule

// ==== verification/fault_bank_asserts.sv ====
// Checker for the fault bank: read answer, alert and summary timing.
// Assumes it is bound onto the bank and sees only its ports.
`timescale 1ns/100ps
module fault_bank_asserts (
  input logic        CLK, RESETN, READ_STROBE, CLEAR_STROBE, READ_VALID, READ_UNKNOWN,
  input logic        ALERT_N_OE, DEVICE_SUMMARY_FLAG,
  input logic [7:0]  CMD_CODE, CURRENT_EVENTS, INPUT_EVENTS, HEAT_EVENTS, COMM_EVENTS,
  input logic [7:0]  DEVICE_EVENTS, ALERT_MASK,
  input logic [15:0] READ_DATA
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  chk_read_answer: assert property (READ_STROBE |=> READ_VALID) else $error("read unanswered");
  chk_unknown_empty: assert property (READ_UNKNOWN |-> READ_VALID && READ_DATA == 16'h0000)
    else $error("unmapped read data");
  chk_current_zero: assert property (READ_VALID && $past(CMD_CODE) == 8'h7b |->
    (READ_DATA & 16'hff57) == 16'h0000) else $error("current byte spare bit");
  chk_common_alert: assert property (READ_VALID && $past(CMD_CODE) == 8'hef |->
    READ_DATA[7] == !$past(ALERT_N_OE)) else $error("common alert bit");
  chk_alert_raise: assert property (CURRENT_EVENTS[7] && !ALERT_MASK[0] ##1 !ALERT_MASK[0] |=> ALERT_N_OE)
    else $error("alert not raised");
  chk_alert_masked: assert property (ALERT_MASK[4:0] == 5'h1f |=> !ALERT_N_OE) else $error("masked alert");
  chk_alert_release: assert property (CLEAR_STROBE &&
    (CURRENT_EVENTS | INPUT_EVENTS | HEAT_EVENTS | COMM_EVENTS | DEVICE_EVENTS) == 8'h00 |-> ##2 !ALERT_N_OE)
    else $error("alert kept");
  chk_summary_set: assert property (|(DEVICE_EVENTS & 8'hfb) |-> ##2 DEVICE_SUMMARY_FLAG)
    else $error("summary not set");
  chk_summary_drop: assert property (CLEAR_STROBE && DEVICE_EVENTS == 8'h00 |=> ##1 !DEVICE_SUMMARY_FLAG)
    else $error("summary kept");
endmodule
bind pmbus_fault_status_bank fault_bank_asserts u_fault_bank_asserts (.*);

// ==== verification/host_model.sv ====
// Host side model: reads, one-to-clear writes and clear-faults as decoder strobes.
// Assumes the bank samples strobes on the rising CLK edge.
`timescale 1ns/100ps
module host_model (
  input  logic        CLK,
  input  logic        READ_VALID,
  input  logic [15:0] READ_DATA,
  output logic [7:0]  CMD_CODE = 8'h00,
  output logic [7:0]  WRITE_DATA = 8'h00,
  output logic        WRITE_STROBE = 1'b0,
  output logic        CLEAR_STROBE = 1'b0,
  output logic        READ_STROBE = 1'b0
);
  task automatic op(input logic [7:0] c, input logic [7:0] d, input logic [2:0] s);
    @(posedge CLK) #1;
    CMD_CODE = c;
    WRITE_DATA = d;
    {WRITE_STROBE, CLEAR_STROBE, READ_STROBE} = s;
    @(posedge CLK) #1;
    {WRITE_STROBE, CLEAR_STROBE, READ_STROBE} = 3'h0;
    // Released data is inverted so nothing can lean on a stale byte.
    WRITE_DATA = ~d;
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] q);
    op(c, 8'h00, 3'h1);
    q = READ_VALID ? READ_DATA : 16'hdead;
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    op(c, d, 3'h4);
  endtask
  task automatic clr;
    op(8'h03, 8'h00, 3'h2);
  endtask
endmodule

// ==== verification/tb.sv ====
// Self-checking bench for the fault and status bank.
// Assumes the host model and checker are compiled ahead of it.
`timescale 1ns/100ps
module tb;
  logic        CLK = 1'b0, RESETN = 1'b0;
  logic [7:0]  CMD_CODE, WRITE_DATA, ALERT_MASK, CURRENT_EVENTS, INPUT_EVENTS, HEAT_EVENTS, COMM_EVENTS;
  logic [7:0]  DEVICE_EVENTS;
  logic        WRITE_STROBE, CLEAR_STROBE, READ_STROBE, READ_VALID, READ_UNKNOWN, ALERT_N_OE;
  logic        DEVICE_SUMMARY_FLAG, TEMP_MAYBE_INVALID, NOT_BUSY, NO_CALC_PENDING, OUTPUT_STEADY;
  logic        MEMORY_INITIALIZED, ECC_CORRECTED, SYNC_DISABLED_PIN, CHANNEL_ZERO_ENABLE_PIN;
  logic        CHANNEL_ONE_ENABLE_PIN, CHANNEL_ZERO_FAULT_LINE, CHANNEL_ONE_FAULT_LINE, SHARED_TIMEBASE_TIMEOUT;
  logic [1:0]  STAGES_READY, POWER_GOOD, FORCING_ENABLE_LOW, FORCING_FAULT_LOW;
  logic [15:0] READ_DATA, q;
  int          err_count = 0, checks_done = 0;
  pmbus_fault_status_bank u_pmbus_fault_status_bank (.*);
  host_model u_host_model (.*);
  always #50 CLK = ~CLK;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdchk(input logic [7:0] c, input logic [15:0] e);
    u_host_model.rd(c, q);
    chk($sformatf("read %h", c), e, q);
  endtask
  task automatic fire(input logic [39:0] v);
    @(posedge CLK) #1;
    {CURRENT_EVENTS, INPUT_EVENTS, HEAT_EVENTS, COMM_EVENTS, DEVICE_EVENTS} = v;
    @(posedge CLK) #1;
    {CURRENT_EVENTS, INPUT_EVENTS, HEAT_EVENTS, COMM_EVENTS, DEVICE_EVENTS} = 40'h0;
  endtask
  task automatic t_sticky;
    logic [7:0]  c [6] = '{8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h80, 8'h79};
    logic [15:0] e [6] = '{16'h00a8, 16'h00a8, 16'h00c0, 16'h00fb, 16'h00fb, 16'h1000};
    fire({5{8'hff}});
    for (int i = 0; i < 6; i++) rdchk(c[i], e[i]);
    chk("alert", 16'h0001, ALERT_N_OE);
    chk("summary", 16'h0001, DEVICE_SUMMARY_FLAG);
    $display("sticky done");
  endtask
  task automatic t_w1c;
    u_host_model.wr(8'h7b, 8'h80);
    u_host_model.wr(8'h7b, 8'h00);
    u_host_model.wr(8'h7c, 8'hff);
    rdchk(8'h7b, 16'h0028);
    rdchk(8'h7c, 16'h0028);
    u_host_model.wr(8'h7e, 8'h0f);
    rdchk(8'h7e, 16'h00f0);
    u_host_model.wr(8'h80, 8'hfb);
    rdchk(8'h80, 16'h0000);
    rdchk(8'h79, 16'h0000);
    chk("summary cleared", 16'h0000, DEVICE_SUMMARY_FLAG);
    $display("w1c done");
  endtask
  task automatic t_clear;
    COMM_EVENTS = 8'h01;
    u_host_model.clr();
    rdchk(8'h7c, 16'h0000);
    rdchk(8'h7e, 16'h0001);
    chk("alert", 16'h0001, ALERT_N_OE);
    COMM_EVENTS = 8'h00;
    u_host_model.clr();
    rdchk(8'h55, 16'h0000);
    chk("unknown", 16'h0001, READ_UNKNOWN);
    chk("alert", 16'h0000, ALERT_N_OE);
    $display("clear done");
  endtask
  task automatic t_mask;
    ALERT_MASK = 8'h1f;
    fire({5{8'hff}});
    rdchk(8'h7d, 16'h00c0);
    chk("masked alert", 16'h0000, ALERT_N_OE);
    ALERT_MASK = 8'h00;
    u_host_model.clr();
    fire(40'h0028000000);
    rdchk(8'h7c, 16'h0028);
    chk("input alert", 16'h0000, ALERT_N_OE);
    $display("mask done");
  endtask
  task automatic t_live;
    {STAGES_READY, POWER_GOOD, FORCING_ENABLE_LOW, FORCING_FAULT_LOW} = 8'h99;
    {TEMP_MAYBE_INVALID, NOT_BUSY, NO_CALC_PENDING, OUTPUT_STEADY, MEMORY_INITIALIZED, ECC_CORRECTED} = 6'h36;
    {SYNC_DISABLED_PIN, CHANNEL_ZERO_ENABLE_PIN, CHANNEL_ONE_ENABLE_PIN} = 3'h6;
    {CHANNEL_ZERO_FAULT_LINE, CHANNEL_ONE_FAULT_LINE, SHARED_TIMEBASE_TIMEOUT} = 3'h3;
    repeat (3) @(posedge CLK);
    rdchk(8'he5, 16'h8d96);
    rdchk(8'hef, 16'h00da);
    rdchk(8'hb6, 16'h0020);
    $display("live done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    {ALERT_MASK, CURRENT_EVENTS, INPUT_EVENTS, HEAT_EVENTS, COMM_EVENTS, DEVICE_EVENTS} = 48'h0;
    {STAGES_READY, POWER_GOOD, FORCING_ENABLE_LOW, FORCING_FAULT_LOW} = 8'h00;
    {TEMP_MAYBE_INVALID, NOT_BUSY, NO_CALC_PENDING, OUTPUT_STEADY, MEMORY_INITIALIZED, ECC_CORRECTED} = 6'h00;
    {SYNC_DISABLED_PIN, CHANNEL_ZERO_ENABLE_PIN, CHANNEL_ONE_ENABLE_PIN} = 3'h0;
    {CHANNEL_ZERO_FAULT_LINE, CHANNEL_ONE_FAULT_LINE, SHARED_TIMEBASE_TIMEOUT} = 3'h0;
    repeat (6) @(posedge CLK);
    #1 RESETN = 1'b1;
    t_sticky;
    t_w1c;
    t_clear;
    t_mask;
    t_live;
    summarize;
  end
  initial begin
    // Roughly four times the length of the whole sequence.
    #30000;
    err_count++;
    summarize;
  end
endmodule
